// File: ddr_burst_cfg.svh
// Build constants for the two-word burst DDR SRAM port
`ifndef DDR_BURST_CFG_SVH
`define DDR_BURST_CFG_SVH

`define ADDR_W        20
`define DATA_W        18
`define MEM_WORDS     (1 << `ADDR_W)

// Half-cycle edges per clock cycle: one on the true clock, one on its complement
`define HALF_PER_CYC  2
// Read latencies in tenths of a clock cycle
`define LAT_ON_X10    15
`define LAT_OFF_X10   10
`define LAT_ON_HALF   ((`LAT_ON_X10 * `HALF_PER_CYC) / 10)
`define LAT_OFF_HALF  ((`LAT_OFF_X10 * `HALF_PER_CYC) / 10)
`define RS_DEPTH      4

`define ECHO_IDLE     2'h0
`define ECHO_WORD0    2'h1
`define ECHO_WORD1    2'h2

`endif

// File: ddr_burst_pkg.sv
// Types shared by the burst port modules
`include "ddr_burst_cfg.svh"
package ddr_burst_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] word_t;

    typedef enum logic [2:0] {
        LK_IDLE = 3'h1,
        LK_W0   = 3'h2,
        LK_W1   = 3'h4
    } link_st_t;

    typedef struct packed {
        logic  load_n;
        logic  read;
        addr_t addr;
    } cmd_t;

    typedef struct packed {
        logic  we;
        addr_t waddr;
        word_t wdata;
        addr_t raddr;
    } mem_req_t;

    typedef struct packed {
        logic                   ph;
        logic [2:0]             ws;
        logic [`RS_DEPTH-1:0]   rs;
        addr_t                  wa1;
        addr_t                  wa2;
        addr_t                  ra;
        word_t                  din;
        word_t                  d1;
        word_t                  bw0;
        word_t                  bw1;
        logic                   keep;
        logic                   req_t;
        logic                   busy;
        logic                   ack_seen;
    } core_st_t;

    typedef struct packed {
        link_st_t   st;
        logic       req_seen;
        logic       ack_t;
        word_t      dq;
        logic       oe;
        logic [1:0] echo;
    } link_st_s_t;
endpackage

// File: ddr_burst_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module ddr_burst_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,   // Destination clock
    input  wire logic         nrst_i,  // Async reset, active low
    input  wire logic [W-1:0] d_i,     // Level from another domain
    output logic      [W-1:0] q_o      // Synchronised level
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sy_t;

    sy_t s_q;
    sy_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = d_i;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.sync;
endmodule
`default_nettype wire

// File: ddr_burst_mem.sv
// Storage array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
`include "ddr_burst_cfg.svh"
module ddr_burst_mem (
    input  wire logic                     clk_i,   // Core clock
    input  wire ddr_burst_pkg::mem_req_t  req_i,   // Write and read request
    output logic      [`DATA_W-1:0]       rdata_o  // Read word, one edge late
);
    ddr_burst_pkg::word_t mem_q [`MEM_WORDS];
    ddr_burst_pkg::word_t rd_q;

    // No reset on the data path: array and read word start undefined
    always_ff @(posedge clk_i) begin
        if (req_i.we) begin
            mem_q[req_i.waddr] <= req_i.wdata;
        end
        rd_q <= mem_q[req_i.raddr];
    end

    assign rdata_o = rd_q;
endmodule
`default_nettype wire

// File: ddr_burst_port.sv
// Two-word burst DDR SRAM port: input capture, array access, output launch
`timescale 1ns/100ps
`default_nettype none
`include "ddr_burst_cfg.svh"

// Operation
// R1 - An address is taken only on every second rising input edge, one per two edges.
// R2 - Write words are taken on the true and the complementary input edges, one each.
// R3 - Read words leave on rising edges of the output clock pair.
// R4 - A one-bit burst counter starts at the low address bit and moves two words per address.
// R5 - The array holds one mega-word of 18 bits (or 512 kilo-words of 36 bits).
// R6 - With the loop on, read data appear one and a half cycles after the address.
// R7 - With the loop bypassed, read data appear one cycle after the address.
// R8 - Echo strobes are driven in step with the read words.
// R9 - Every synchronous input passes an input register on the input clock.
// R10 - Every data output passes an output register on the output clock.
// R11 - Array writes are timed inside the device once the data are captured.
// R12 - Only rising clock edges are used; both clock phases give the double rate.
// R13 - The shared data lines are driven by the device only while read words leave.
// R14 - The controller samples read words on the echo strobes and crosses them itself.
module ddr_burst_port (
    input  wire logic                    clk_i,              // Input clock, one edge per half cycle
    input  wire logic                    nrst_i,             // Async reset, active low
    input  wire logic                    link_clk_i,         // Output clock, one edge per word
    input  wire logic                    loop_bypass_pin_i,  // High: delay loop bypassed
    input  wire ddr_burst_pkg::cmd_t     cmd_i,              // Load, read/write and address
    input  wire logic [`DATA_W-1:0]      dq_i,               // Data lines, sensed
    output logic      [`DATA_W-1:0]      dq_o,               // Data lines, driven
    output logic                         dq_oe_o,            // Data lines enable
    output logic      [1:0]              echo_strobe_pair_o  // Echo strobes, bit 1 complement
);
    ddr_burst_pkg::core_st_t   c_q;
    ddr_burst_pkg::core_st_t   c_d;
    ddr_burst_pkg::link_st_s_t l_q;
    ddr_burst_pkg::link_st_s_t l_d;
    ddr_burst_pkg::mem_req_t   mreq;
    ddr_burst_pkg::word_t      rdata;
    ddr_burst_pkg::word_t      w_src;
    logic                      loop_off;
    logic                      ack_s;
    logic                      req_s;
    logic                      req_edge;
    logic                      w0_go;
    logic                      w1_go;

    // Second word of a burst: the one-bit counter wraps inside the pair
    function automatic ddr_burst_pkg::addr_t burst_next(input ddr_burst_pkg::addr_t a);
        burst_next = {a[`ADDR_W-1:1], ~a[0]};                       // [R4]
    endfunction

    // Strap pin is static but asynchronous to the core
    ddr_burst_sync #(
        .W (1)
    ) u_loop_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (loop_bypass_pin_i),
        .q_o    (loop_off)
    );

    ddr_burst_sync #(
        .W (1)
    ) u_ack_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (l_q.ack_t),
        .q_o    (ack_s)
    );

    ddr_burst_sync #(
        .W (1)
    ) u_req_sync (
        .clk_i  (link_clk_i),
        .nrst_i (nrst_i),
        .d_i    (c_q.req_t),
        .q_o    (req_s)
    );

    ddr_burst_mem u_mem (                                            // [R5]
        .clk_i   (clk_i),
        .req_i   (mreq),
        .rdata_o (rdata)
    );

    // Launch points follow the loop mode; the loop-on path takes one more half cycle
    assign w0_go = loop_off ? c_q.rs[`LAT_OFF_HALF-1] : c_q.rs[`LAT_ON_HALF-1]; // [R6] [R7]
    assign w1_go = loop_off ? c_q.rs[`LAT_OFF_HALF] : c_q.rs[`LAT_ON_HALF];     // [R6] [R7]
    assign w_src = loop_off ? rdata : c_q.d1;

    // Array port: each word is written one edge after it sits in the input register
    always_comb begin
        mreq.we    = c_q.ws[1] | c_q.ws[2];                          // [R11]
        mreq.waddr = c_q.ws[1] ? c_q.wa1 : burst_next(c_q.wa2);      // [R4]
        mreq.wdata = c_q.din;
        mreq.raddr = c_q.rs[1] ? burst_next(c_q.ra) : c_q.ra;        // [R4]
    end

    // Core side, one edge per half cycle of the input clock pair
    always_comb begin
        c_d      = c_q;
        c_d.ph   = ~c_q.ph;
        c_d.ws   = {c_q.ws[1:0], 1'h0};
        c_d.rs   = {c_q.rs[`RS_DEPTH-2:0], 1'h0};
        c_d.din  = dq_i;                                             // [R9] [R2]
        c_d.d1   = rdata;
        if (!c_q.ph && !cmd_i.load_n) begin                          // [R1]
            if (cmd_i.read) begin
                c_d.rs[0] = 1'h1;
                c_d.ra    = cmd_i.addr;
            end else begin
                c_d.ws[0] = 1'h1;
                c_d.wa1   = cmd_i.addr;
            end
        end
        if (c_q.ws[1]) begin
            c_d.wa2 = c_q.wa1;
        end
        if (ack_s != c_q.ack_seen) begin
            c_d.ack_seen = ack_s;
            c_d.busy     = 1'h0;
        end
        // A burst meeting a busy crossing is dropped whole, never torn
        if (w0_go) begin
            c_d.keep = ~c_d.busy;
            if (!c_d.busy) begin
                c_d.bw0 = w_src;
            end
        end
        if (w1_go && c_q.keep) begin
            c_d.bw1   = w_src;
            c_d.req_t = ~c_q.req_t;
            c_d.busy  = 1'h1;
            c_d.keep  = 1'h0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin               // [R12]
        if (!nrst_i) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    // Link side: burst words stay still while the request toggle is pending
    assign req_edge = (req_s != l_q.req_seen);

    always_comb begin
        l_d = l_q;
        case (l_q.st)
            ddr_burst_pkg::LK_IDLE: begin
                l_d.oe   = 1'h0;                                     // [R13]
                l_d.echo = `ECHO_IDLE;
                if (req_edge) begin
                    l_d.req_seen = req_s;
                    l_d.st       = ddr_burst_pkg::LK_W0;
                    l_d.dq       = c_q.bw0;                          // [R3] [R10]
                    l_d.oe       = 1'h1;
                    l_d.echo     = `ECHO_WORD0;                      // [R8]
                end
            end
            ddr_burst_pkg::LK_W0: begin
                l_d.st   = ddr_burst_pkg::LK_W1;
                l_d.dq   = c_q.bw1;                                  // [R3] [R10]
                l_d.echo = `ECHO_WORD1;                              // [R8]
            end
            ddr_burst_pkg::LK_W1: begin
                l_d.st    = ddr_burst_pkg::LK_IDLE;
                l_d.oe    = 1'h0;                                    // [R13]
                l_d.echo  = `ECHO_IDLE;
                l_d.ack_t = ~l_q.ack_t;
            end
            default: begin
                l_d.st   = ddr_burst_pkg::LK_IDLE;
                l_d.oe   = 1'h0;
                l_d.echo = `ECHO_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk_i or negedge nrst_i) begin          // [R12]
        if (!nrst_i) begin
            l_q <= '{st: ddr_burst_pkg::LK_IDLE, default: '0};
        end else begin
            l_q <= l_d;
        end
    end

    assign dq_o               = l_q.dq;
    assign dq_oe_o            = l_q.oe;
    assign echo_strobe_pair_o = l_q.echo;

    // Checks on the core side
    sequence rd_taken_off_s;
        c_q.rs[0] && loop_off;
    endsequence

    sequence rd_taken_on_s;
        c_q.rs[0] && !loop_off;
    endsequence

    sequence wr_first_s;
        c_q.ws[1] && mreq.we;
    endsequence

    addr_phase_a: assert property (                                  // [R1]
        @(posedge clk_i) disable iff (!nrst_i)
        (c_q.rs[0] || c_q.ws[0]) |-> c_q.ph
    ) else $error("command taken on the wrong half cycle");

    wr_words_a: assert property (                                    // [R2]
        @(posedge clk_i) disable iff (!nrst_i)
        c_q.ws[0] |=> (mreq.we && mreq.wdata == $past(dq_i)) ##1 (mreq.we && mreq.wdata == $past(dq_i))
    ) else $error("write word not taken on consecutive edges");

    burst_pair_a: assert property (                                  // [R4]
        @(posedge clk_i) disable iff (!nrst_i)
        wr_first_s |=> mreq.we && (mreq.waddr == burst_next($past(mreq.waddr)))
    ) else $error("second burst word at wrong address");

    self_write_a: assert property (                                  // [R11]
        @(posedge clk_i) disable iff (!nrst_i)
        c_q.ws[0] |=> mreq.we ##1 mreq.we
    ) else $error("captured write not placed in array");

    lat_off_a: assert property (                                     // [R7]
        @(posedge clk_i) disable iff (!nrst_i)
        rd_taken_off_s |=> w0_go ##1 w1_go
    ) else $error("bypass read latency wrong");

    lat_on_a: assert property (                                      // [R6]
        @(posedge clk_i) disable iff (!nrst_i)
        rd_taken_on_s |=> !w0_go ##1 w0_go ##1 w1_go
    ) else $error("loop-on read latency wrong");

    // Checks on the link side
    link_launch_a: assert property (                                 // [R3]
        @(posedge link_clk_i) disable iff (!nrst_i)
        (l_q.st == ddr_burst_pkg::LK_IDLE && req_edge)
            |=> (l_q.oe && l_q.dq == c_q.bw0) ##1 (l_q.oe && l_q.dq == c_q.bw1)
    ) else $error("read words not launched in order");

    echo_align_a: assert property (                                  // [R8]
        @(posedge link_clk_i) disable iff (!nrst_i)
        l_q.oe |-> (l_q.echo == ((l_q.st == ddr_burst_pkg::LK_W0) ? `ECHO_WORD0 : `ECHO_WORD1))
    ) else $error("echo strobes out of step with data");

    bus_turn_a: assert property (                                    // [R13]
        @(posedge link_clk_i) disable iff (!nrst_i)
        $rose(l_q.oe) |-> l_q.oe [*2] ##1 !l_q.oe
    ) else $error("data lines held beyond the burst");

    // Pacing and pairing on the core side
    sequence odd_cmd_s;
        c_q.ph && !cmd_i.load_n;
    endsequence

    sequence rd_launch_s;
        w1_go && c_q.keep;
    endsequence

    odd_edge_a: assert property (                                    // [R1]
        @(posedge clk_i) disable iff (!nrst_i)
        odd_cmd_s |=> !(c_q.rs[0] || c_q.ws[0])
    ) else $error("command taken on an in-between edge");

    cmd_spacing_a: assert property (                                 // [R1]
        @(posedge clk_i) disable iff (!nrst_i)
        (c_q.rs[0] || c_q.ws[0]) |=> !(c_q.rs[0] || c_q.ws[0])
    ) else $error("two commands on adjacent edges");

    rd_pair_addr_a: assert property (                                // [R4]
        @(posedge clk_i) disable iff (!nrst_i)
        c_q.rs[0] |-> (mreq.raddr == c_q.ra) ##1 (mreq.raddr == burst_next($past(c_q.ra)))
    ) else $error("read burst fetched at wrong addresses");

    // A burst that meets a busy crossing must vanish whole, never half sent
    drop_whole_a: assert property (                                  // [R4]
        @(posedge clk_i) disable iff (!nrst_i)
        (w0_go && c_q.busy && (ack_s == c_q.ack_seen)) |=> !c_q.keep
    ) else $error("burst kept although the crossing was busy");

    no_half_burst_a: assert property (                               // [R4]
        @(posedge clk_i) disable iff (!nrst_i)
        (w1_go && !c_q.keep) |=> $stable(c_q.req_t)
    ) else $error("request raised for a dropped burst");

    launch_busy_a: assert property (                                 // [R4]
        @(posedge clk_i) disable iff (!nrst_i)
        rd_launch_s |=> c_q.busy && (c_q.req_t != $past(c_q.req_t))
    ) else $error("kept burst not handed to the output side");

    // The output side reads the burst words raw, so they must hold while in flight
    one_in_flight_a: assert property (                               // [R10]
        @(posedge clk_i) disable iff (!nrst_i)
        $changed(c_q.req_t) |-> !$past(c_q.busy)
    ) else $error("request toggled while a burst was in flight");

    held_words_a: assert property (                                  // [R10]
        @(posedge clk_i) disable iff (!nrst_i)
        (c_q.busy && $past(c_q.busy)) |-> $stable(c_q.bw0) && $stable(c_q.bw1)
    ) else $error("burst words moved while crossing");

    ack_free_a: assert property (                                    // [R10]
        @(posedge clk_i) disable iff (!nrst_i)
        ((ack_s != c_q.ack_seen) && !(w1_go && c_q.keep)) |=> !c_q.busy
    ) else $error("returned acknowledge did not free the crossing");

    // Pacing on the output side
    sequence link_idle_s;
        l_q.st == ddr_burst_pkg::LK_IDLE;
    endsequence

    sequence burst_tail_s;
        l_q.st == ddr_burst_pkg::LK_W1;
    endsequence

    idle_quiet_a: assert property (                                  // [R13]
        @(posedge link_clk_i) disable iff (!nrst_i)
        link_idle_s |-> !l_q.oe && (l_q.echo == `ECHO_IDLE)
    ) else $error("lines or echo driven while idle");

    word_drive_a: assert property (                                  // [R13]
        @(posedge link_clk_i) disable iff (!nrst_i)
        (l_q.st != ddr_burst_pkg::LK_IDLE) |-> l_q.oe
    ) else $error("read word left undriven");

    echo_next_a: assert property (                                   // [R8]
        @(posedge link_clk_i) disable iff (!nrst_i)
        (l_q.st == ddr_burst_pkg::LK_W0)
            |=> (l_q.st == ddr_burst_pkg::LK_W1) && (l_q.echo == `ECHO_WORD1)
    ) else $error("second word or its echo missing");

    tail_ack_a: assert property (                                    // [R3]
        @(posedge link_clk_i) disable iff (!nrst_i)
        burst_tail_s |=> (l_q.st == ddr_burst_pkg::LK_IDLE) && (l_q.ack_t != $past(l_q.ack_t))
    ) else $error("burst end not acknowledged");

    req_when_idle_a: assert property (                               // [R3]
        @(posedge link_clk_i) disable iff (!nrst_i)
        req_edge |-> link_idle_s
    ) else $error("new burst requested before the last one ended");
endmodule
`default_nettype wire

// File: ctrl_model.sv
// Memory controller model: resolves the shared data lines and captures read bursts
`timescale 1ns/100ps
`default_nettype none
`include "ddr_burst_cfg.svh"
module ctrl_model (
    input  wire logic               clk_i,      // Input clock
    input  wire logic               nrst_i,     // Async reset, active low
    input  wire logic               link_clk_i, // Output clock
    input  wire logic [`DATA_W-1:0] dev_dq_i,   // Word driven by device
    input  wire logic               dev_oe_i,   // Device drive enable
    input  wire logic [1:0]         echo_i,     // Echo strobes
    input  wire logic [`DATA_W-1:0] wr_dq_i,    // Write word from bench
    input  wire logic               wr_oe_i,    // Bench drive enable
    output logic      [`DATA_W-1:0] dq_o,       // Resolved line level
    output logic      [`DATA_W-1:0] rd_w0_o,    // First read word
    output logic      [`DATA_W-1:0] rd_w1_o,    // Second read word
    output logic      [1:0]         rd_oe_o,    // Enable seen with each word
    output logic      [15:0]        rd_cnt_o    // Words captured
);
    logic [`DATA_W-1:0] last_q;
    // Released lines flip every cycle so a stale word never looks valid
    assign dq_o = dev_oe_i ? dev_dq_i : (wr_oe_i ? wr_dq_i : ~last_q);
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) last_q <= '0;
        else last_q <= dq_o;
    end
    // Words are taken on the echo strobes in the output clock domain
    always @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_cnt_o <= 16'h0000;
        end else if (echo_i == 2'h1) begin
            rd_w0_o    <= dev_dq_i;
            rd_oe_o[0] <= dev_oe_i;
            rd_cnt_o   <= rd_cnt_o + 16'h0001;
        end else if (echo_i == 2'h2) begin
            rd_w1_o    <= dev_dq_i;
            rd_oe_o[1] <= dev_oe_i;
            rd_cnt_o   <= rd_cnt_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the two-word burst port
`timescale 1ns/100ps
`default_nettype none
`include "ddr_burst_cfg.svh"
module testbench;
    logic                 clk_i = 1'b0;
    logic                 link_clk_i = 1'b0;
    logic                 nrst_i = 1'b0;
    logic                 loop_bypass_pin_i = 1'b1;
    ddr_burst_pkg::cmd_t  cmd_i = '{load_n: 1'b1, read: 1'b0, addr: '0};
    ddr_burst_pkg::word_t wr_dq = '0;
    logic                 wr_oe = 1'b0;
    logic [`DATA_W-1:0]   dq_i, dq_o, rd_w0, rd_w1;
    logic                 dq_oe_o;
    logic [1:0]           echo, rd_oe;
    logic [15:0]          rd_cnt;
    int                   err_total = 0;
    int                   compares = 0;
    int                   edge_n = 0;
    always #2.5 clk_i = ~clk_i;
    // Skewed start keeps the output clock off the input clock grid
    initial begin
        #1.3;
        forever #80 link_clk_i = ~link_clk_i;
    end
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) edge_n <= 0;
        else edge_n <= edge_n + 1;
    end
    ddr_burst_port ddr_burst_port_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i),
        .loop_bypass_pin_i(loop_bypass_pin_i), .cmd_i(cmd_i), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .echo_strobe_pair_o(echo));
    ctrl_model ctrl_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(link_clk_i),
        .dev_dq_i(dq_o), .dev_oe_i(dq_oe_o), .echo_i(echo), .wr_dq_i(wr_dq), .wr_oe_i(wr_oe),
        .dq_o(dq_i), .rd_w0_o(rd_w0), .rd_w1_o(rd_w1), .rd_oe_o(rd_oe), .rd_cnt_o(rd_cnt));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Leaves the bench at a falling edge whose next rising edge takes an address
    task automatic at_addr_edge();
        @(negedge clk_i);
        if (edge_n[0] == 1'b1) @(negedge clk_i);
    endtask
    task automatic wr(input ddr_burst_pkg::addr_t a, input ddr_burst_pkg::word_t w0, w1);
        at_addr_edge();
        cmd_i = '{load_n: 1'b0, read: 1'b0, addr: a};
        @(negedge clk_i);
        cmd_i.load_n = 1'b1;
        wr_oe = 1'b1;
        wr_dq = w0;
        @(negedge clk_i);
        wr_dq = w1;
        chk(dq_oe_o, 32'h0000_0000, "device drives during write");
        @(negedge clk_i);
        wr_oe = 1'b0;
    endtask
    task automatic rd(input ddr_burst_pkg::addr_t a, input ddr_burst_pkg::word_t e0, e1);
        logic [15:0] n0;
        int          i;
        n0 = rd_cnt;
        at_addr_edge();
        cmd_i = '{load_n: 1'b0, read: 1'b1, addr: a};
        @(negedge clk_i);
        cmd_i.load_n = 1'b1;
        i = 0;
        while (rd_cnt !== n0 + 16'h0002 && i < 400) begin
            @(negedge clk_i);
            i++;
        end
        if (i >= 400) begin
            err_total++;
            $display("wrong value at %0t: read burst never arrived", $time);
            final_report();
        end
        chk(rd_w0, e0, "first read word");
        chk(rd_w1, e1, "second read word");
        chk(rd_oe, 32'h0000_0003, "drive enable with words");
        repeat (40) @(negedge clk_i);
        chk(echo, 32'h0000_0000, "echo idle after burst");
        chk(dq_oe_o, 32'h0000_0000, "lines released after burst");
    endtask
    task automatic t_basic();
        wr(20'h0_0010, 18'h2_a5c3, 18'h1_5a3c);
        rd(20'h0_0010, 18'h2_a5c3, 18'h1_5a3c);
        rd(20'h0_0011, 18'h1_5a3c, 18'h2_a5c3);
        $display("test basic done");
    endtask
    task automatic t_boundary();
        wr(20'hf_ffff, 18'h3_0f0f, 18'h0_f0f0);
        rd(20'hf_fffe, 18'h0_f0f0, 18'h3_0f0f);
        $display("test boundary done");
    endtask
    // A command on an in-between edge must not reach the array
    task automatic t_odd_edge();
        at_addr_edge();
        @(negedge clk_i);
        cmd_i = '{load_n: 1'b0, read: 1'b0, addr: 20'h0_0010};
        @(negedge clk_i);
        cmd_i.load_n = 1'b1;
        wr_oe = 1'b1;
        wr_dq = 18'h3_ffff;
        @(negedge clk_i);
        wr_dq = 18'h0_0001;
        @(negedge clk_i);
        wr_oe = 1'b0;
        rd(20'h0_0010, 18'h2_a5c3, 18'h1_5a3c);
        $display("test odd edge done");
    endtask
    task automatic t_loop_on();
        @(negedge clk_i);
        loop_bypass_pin_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rd(20'h0_0011, 18'h1_5a3c, 18'h2_a5c3);
        @(negedge clk_i);
        loop_bypass_pin_i = 1'b1;
        repeat (4) @(negedge clk_i);
        $display("test loop on done");
    endtask
    // Second read comes while the first still crosses and is dropped whole
    task automatic t_drop();
        logic [15:0] n0;
        n0 = rd_cnt;
        at_addr_edge();
        cmd_i = '{load_n: 1'b0, read: 1'b1, addr: 20'hf_fffe};
        @(negedge clk_i);
        cmd_i.load_n = 1'b1;
        @(negedge clk_i);
        cmd_i = '{load_n: 1'b0, read: 1'b1, addr: 20'h0_0010};
        @(negedge clk_i);
        cmd_i.load_n = 1'b1;
        repeat (300) @(negedge clk_i);
        chk(rd_cnt, n0 + 16'h0002, "words after back-to-back reads");
        chk(rd_w0, 18'h0_f0f0, "first burst kept");
        chk(rd_w1, 18'h3_0f0f, "first burst second word");
        $display("test drop done");
    endtask
    initial begin
        repeat (4) @(posedge link_clk_i);
        chk(dq_oe_o, 32'h0000_0000, "enable in reset");
        chk(echo, 32'h0000_0000, "echo in reset");
        chk(dq_o, 32'h0000_0000, "data in reset");
        @(negedge clk_i);
        nrst_i = 1'b1;
        t_basic();
        t_boundary();
        t_odd_edge();
        t_loop_on();
        t_drop();
        final_report();
    end
endmodule
`default_nettype wire
